/* rtl/bsr_cfg.svh */
// Purpose: Named constants for the blind relay controller
// Assumes: 40 MHz ref_clk, times held in milliseconds
// Notes: Register offsets are byte addresses on AXI4-Lite
`ifndef BSR_CFG_SVH
`define BSR_CFG_SVH
`define BSR_CLK_PERIOD_NS 25
`define BSR_MS_NS 1000000
`define BSR_MS_CYCLES ((`BSR_MS_NS + `BSR_CLK_PERIOD_NS - 1) / `BSR_CLK_PERIOD_NS)
`define BSR_SHORT_MS 16'h015e
`define BSR_GAP_MS 16'h0bb8
`define BSR_JOG_MS 16'h012c
`define BSR_OFFDLY_DIV 16'h0014
`define BSR_TOL_MUL 19'h00005
`define BSR_SLAT_DEF_MS 16'h03e8
`define BSR_STEPS_DEF 8'h0a
`define BSR_STEPS_MIN 4'h5
`define BSR_STEPS_MAX 4'hf
`define BSR_SLAT_DIV 20'h0000a
`define BSR_A_CTRL 8'h00
`define BSR_A_STAT 8'h04
`define BSR_A_UPT 8'h08
`define BSR_A_DNT 8'h0c
`define BSR_A_SLT 8'h10
`define BSR_A_STP 8'h14
`define BSR_C_BIST 0
`define BSR_C_BLIND 1
`define BSR_C_TCAL 2
`define BSR_C_SCAL 3
`define BSR_C_DEF 4
`define BSR_S_PASS 4
`define BSR_S_FAIL 5
`define BSR_RESP_OK 2'h0
`define BSR_RESP_DEC 2'h3
`endif

/* rtl/bsr_pkg.sv */
// Purpose: Types for the blind relay controller
// Assumes: Constants live in bsr_cfg.svh
// Notes: State codes are one-hot
package bsr_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_UP = 3'b010,
    M_DN = 3'b100
  } bsr_mot_t;
  typedef enum logic [4:0] {
    C_OFF = 5'b00001,
    C_TRAV = 5'b00010,
    C_SLAT = 5'b00100,
    C_JOGU = 5'b01000,
    C_JOGD = 5'b10000
  } bsr_cal_t;
  typedef struct packed {
    logic blindMode;
    logic bistable;
  } bsr_ctrl_t;
endpackage : bsr_pkg

/* rtl/bsr_blind_ctrl.sv */
// Purpose: Time-based blind/shutter relay controller with calibration
// Assumes: Switch inputs synchronous to ref_clk, high means closed
// Notes: Software reaches timing and control over AXI4-Lite
// Functional notes
// - Bistable: closed up switch closes up relay
// - Bistable: open up switch opens up relay
// - Bistable: switch change while running stops motor
// - Bistable: closed down switch closes down relay
// - Bistable: open down switch opens down relay
// - Travel times reset to zero, calibration needed
// - Recalibration rejected beyond 20% of stored
// - Two opening times within 20%
// - Two closing times within 20%
// - Travel movements start within 3 s
// - Store mean opening and closing times
// - Success shown by short up-down jog
// - Slat calibration: short press moves one step
// - Up and down step counts equal
// - Step count above 5 and below 15
// - Slat movements start within 3 s
// - Slat calibration needs step count 10
// - New slat time is old times count/10
// - Slat rotation time defaults to 1 s
// - Monostable press under 350 ms steps slats
// - Motor runs extra 5% off-delay
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bsr_cfg.svh"
module bsr_blind_ctrl import bsr_pkg::*; #(
  parameter int unsigned MS_CYCLES = `BSR_MS_CYCLES,
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic upSwitchInput,
  input wire logic downSwitchInput,
  output logic upMotorRelay,
  output logic downMotorRelay,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  bsr_mot_t mot_q, mot_d;
  bsr_cal_t cal_q;
  bsr_ctrl_t ctrl_q;
  logic [31:0] pre_q;
  logic tick_q;
  logic upPrev_q, dnPrev_q, halt_q, used_q;
  logic [15:0] pressMs_q, runMs_q, idleMs_q, limMs_q, limMs_d;
  logic limOn_q, limOn_d;
  logic [15:0] upTime_q, dnTime_q, slatTime_q;
  logic [7:0] steps_q;
  logic [15:0] dur_q [4];
  logic [3:0] cnt_q [4];
  logic [1:0] idx_q;
  logic moved_q, pass_q, fail_q;
  logic awready_q, wready_q, bvalid_q, awFull_q, wFull_q;
  logic arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  wire [31:0] wMask;
  logic [3:0] wStrb_q;

  // Relays are bits of the one-hot motor state, so they never overlap
  assign upMotorRelay = mot_q[1];
  assign downMotorRelay = mot_q[2];
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Switch edges and derived conditions
  wire upSw = upSwitchInput;
  wire dnSw = downSwitchInput;
  wire upRise = upSw & ~upPrev_q;
  wire dnRise = dnSw & ~dnPrev_q;
  wire upFall = ~upSw & upPrev_q;
  wire dnFall = ~dnSw & dnPrev_q;
  wire swChange = (upSw ^ upPrev_q) | (dnSw ^ dnPrev_q);
  wire motIdle = (mot_q == M_IDLE);
  // A run whose own switch reads open, e.g. after a mode change mid-step
  wire runOpen = ((mot_q == M_UP) && !upSw) || ((mot_q == M_DN) && !dnSw);
  wire jogging = (cal_q == C_JOGU) || (cal_q == C_JOGD);
  wire limHit = limOn_q && (runMs_q >= limMs_q);
  wire shortOk = pressMs_q < `BSR_SHORT_MS;
  wire [15:0] upFull = upTime_q + upTime_q / `BSR_OFFDLY_DIV;
  wire [15:0] dnFull = dnTime_q + dnTime_q / `BSR_OFFDLY_DIV;
  wire upFullOn = (upTime_q != 16'h0000) && (cal_q != C_TRAV);
  wire dnFullOn = (dnTime_q != 16'h0000) && (cal_q != C_TRAV);
  wire [15:0] stepMs = (steps_q == 8'h00) ? slatTime_q : slatTime_q / {8'h00, steps_q};
  wire longUp = upSw & ~dnSw & ~used_q & ~shortOk;
  wire longDn = dnSw & ~upSw & ~used_q & ~shortOk;

  // Motor decision: jog first, then the switch mode in force
  always_comb begin
    mot_d = mot_q;
    limMs_d = limMs_q;
    limOn_d = limOn_q;
    if (jogging) begin
      if (motIdle) begin
        mot_d = (cal_q == C_JOGU) ? M_UP : M_DN;
        limMs_d = `BSR_JOG_MS;
        limOn_d = 1'b1;
      end else if (limHit) begin
        mot_d = M_IDLE;
      end
    end else if (ctrl_q.bistable) begin
      if (!motIdle) begin
        if (swChange || limHit) begin
          mot_d = M_IDLE;
        end else if (runOpen) begin
          mot_d = M_IDLE;
        end
      end else if (upSw && !dnSw && !halt_q) begin
        mot_d = M_UP;
        limMs_d = upFull;
        limOn_d = upFullOn;
      end else if (dnSw && !upSw && !halt_q) begin
        mot_d = M_DN;
        limMs_d = dnFull;
        limOn_d = dnFullOn;
      end
    end else begin
      if (!motIdle) begin
        if (limHit || upRise || dnRise) begin
          mot_d = M_IDLE;
        end
      end else if ((upFall || dnFall) && !used_q && shortOk) begin
        mot_d = upFall ? M_UP : M_DN;
        limMs_d = stepMs;
        limOn_d = 1'b1;
      end else if (longUp) begin
        mot_d = M_UP;
        limMs_d = upFull;
        limOn_d = upFullOn;
      end else if (longDn) begin
        mot_d = M_DN;
        limMs_d = dnFull;
        limOn_d = dnFullOn;
      end
    end
  end

  wire startEv = motIdle && (mot_d != M_IDLE);
  wire stopEv = !motIdle && (mot_d == M_IDLE);
  wire startUp = (mot_d == M_UP);

  // Millisecond tick; the divider is long, hence a parameter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pre_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (pre_q == MS_CYCLES - 1);
      pre_q <= (pre_q == MS_CYCLES - 1) ? 32'h0 : pre_q + 32'h1;
    end
  end

  // Motor state and its timers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mot_q <= M_IDLE;
      limMs_q <= 16'h0;
      limOn_q <= 1'b0;
      runMs_q <= 16'h0;
      idleMs_q <= 16'h0;
    end else begin
      mot_q <= mot_d;
      limMs_q <= limMs_d;
      limOn_q <= limOn_d;
      if (startEv) runMs_q <= 16'h0;
      else if (tick_q && !motIdle && runMs_q != 16'hffff) runMs_q <= runMs_q + 16'h1;
      if (startEv || stopEv) idleMs_q <= 16'h0;
      else if (tick_q && motIdle && idleMs_q != 16'hffff) idleMs_q <= idleMs_q + 16'h1;
    end
  end

  // Press tracking; a press that stopped the motor is not reused
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      upPrev_q <= 1'b0;
      dnPrev_q <= 1'b0;
      pressMs_q <= 16'h0;
      used_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      upPrev_q <= upSw;
      dnPrev_q <= dnSw;
      if (upRise || dnRise) pressMs_q <= 16'h0;
      else if (tick_q && (upSw || dnSw) && pressMs_q != 16'hffff) pressMs_q <= pressMs_q + 16'h1;
      if (upRise || dnRise) used_q <= !motIdle;
      else if (startEv) used_q <= 1'b1;
      // Halt holds the stop until both bistable switches are open
      if (ctrl_q.bistable && stopEv && !jogging) halt_q <= 1'b1;
      else if (!upSw && !dnSw) halt_q <= 1'b0;
    end
  end

  // Calibration evaluation terms
  function automatic logic within20(input logic [15:0] base, input logic [15:0] val);
    logic [15:0] diff;
    diff = (val > base) ? val - base : base - val;
    return ({3'b000, diff} * `BSR_TOL_MUL) <= {3'b000, base};
  endfunction : within20
  wire [16:0] sumUp = {1'b0, dur_q[0]} + {1'b0, dur_q[2]};
  wire [16:0] sumDn = {1'b0, dur_q[1]} + {1'b0, runMs_q};
  wire [15:0] meanUp = sumUp[16:1];
  wire [15:0] meanDn = sumDn[16:1];
  wire travOk = within20(dur_q[0], dur_q[2])
    && within20(dur_q[1], runMs_q)
    && (upTime_q == 16'h0 || within20(upTime_q, meanUp))
    && (dnTime_q == 16'h0 || within20(dnTime_q, meanDn));
  wire travEnd = (cal_q == C_TRAV) && stopEv && (idx_q == 2'h3);
  wire startUpPhaseOk = (mot_q == M_DN);
  wire travPass = travEnd && startUpPhaseOk && travOk;
  wire gapOut = moved_q && motIdle && (idleMs_q >= `BSR_GAP_MS);
  wire [3:0] nSteps = cnt_q[0];
  wire slatEq = (cnt_q[1] == nSteps) && (cnt_q[2] == nSteps) && (cnt_q[3] == nSteps);
  wire slatRange = (nSteps > `BSR_STEPS_MIN) && (nSteps < `BSR_STEPS_MAX);
  wire slatPass = (cal_q == C_SLAT) && gapOut && (idx_q == 2'h3) && slatEq && slatRange;
  wire [19:0] slatProd = {4'h0, slatTime_q} * {16'h0, nSteps};
  wire [19:0] slatQuot = slatProd / `BSR_SLAT_DIV;
  wire [15:0] newSlat = slatQuot[15:0];

  // Register write decode
  wire doWrite = awFull_q && wFull_q && !bvalid_q;
  wire wrCtrl = doWrite && (awAddr_q == `BSR_A_CTRL);
  wire wrStat = doWrite && (awAddr_q == `BSR_A_STAT);
  wire wrUpt = doWrite && (awAddr_q == `BSR_A_UPT);
  wire wrDnt = doWrite && (awAddr_q == `BSR_A_DNT);
  wire wrSlt = doWrite && (awAddr_q == `BSR_A_SLT);
  wire wrStp = doWrite && (awAddr_q == `BSR_A_STP);
  wire wrHit = wrCtrl | wrStat | wrUpt | wrDnt | wrSlt | wrStp;
  wire [31:0] wMasked = wData_q & wMask;
  wire tcalGo = wrCtrl && wMasked[`BSR_C_TCAL];
  wire scalGo = wrCtrl && wMasked[`BSR_C_SCAL];
  wire defGo = wrCtrl && wMasked[`BSR_C_DEF];

  // Byte strobes widen to a bit mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_mask
      assign wMask[8*gb +: 8] = {8{wStrb_q[gb]}};
    end
  endgenerate

  // Calibration sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cal_q <= C_OFF;
      idx_q <= 2'h0;
      moved_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        dur_q[i] <= 16'h0;
        cnt_q[i] <= 4'h0;
      end
    end else begin
      // Software clears the sticky flags; a same-cycle set wins
      if (wrStat && wMasked[`BSR_S_PASS]) pass_q <= 1'b0;
      if (wrStat && wMasked[`BSR_S_FAIL]) fail_q <= 1'b0;
      if (startEv) moved_q <= 1'b1;
      case (cal_q)
        C_OFF: begin
          idx_q <= 2'h0;
          moved_q <= 1'b0;
          for (int i = 0; i < 4; i++) cnt_q[i] <= 4'h0;
          if (tcalGo) cal_q <= C_TRAV;
          else if (scalGo && steps_q == `BSR_STEPS_DEF) cal_q <= C_SLAT;
          else if (scalGo) fail_q <= 1'b1;
        end
        C_TRAV: begin
          if (stopEv) begin
            dur_q[idx_q] <= runMs_q;
            idx_q <= idx_q + 2'h1;
            if ((mot_q == M_UP) == idx_q[0]) begin
              cal_q <= C_OFF;
              fail_q <= 1'b1;
            end else if (idx_q == 2'h3) begin
              cal_q <= travPass ? C_JOGU : C_OFF;
              pass_q <= pass_q | travPass;
              fail_q <= fail_q | !travPass;
            end
          end else if (gapOut) begin
            cal_q <= C_OFF;
            fail_q <= 1'b1;
          end
        end
        C_SLAT: begin
          if (startEv) begin
            if (startUp != idx_q[0]) cnt_q[idx_q] <= cnt_q[idx_q] + 4'h1;
            else if (idx_q != 2'h3) begin
              idx_q <= idx_q + 2'h1;
              cnt_q[idx_q + 2'h1] <= 4'h1;
            end else begin
              cal_q <= C_OFF;
              fail_q <= 1'b1;
            end
          end else if (gapOut) begin
            cal_q <= slatPass ? C_JOGU : C_OFF;
            pass_q <= pass_q | slatPass;
            fail_q <= fail_q | !slatPass;
          end
        end
        C_JOGU: if (stopEv) cal_q <= C_JOGD;
        C_JOGD: if (stopEv) cal_q <= C_OFF;
        default: cal_q <= C_OFF;
      endcase
      if (defGo) cal_q <= C_OFF;
    end
  end

  // Stored timing; calibration results win over software writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= '0;
      upTime_q <= 16'h0;
      dnTime_q <= 16'h0;
      slatTime_q <= `BSR_SLAT_DEF_MS;
      steps_q <= `BSR_STEPS_DEF;
    end else if (defGo) begin
      upTime_q <= 16'h0;
      dnTime_q <= 16'h0;
      slatTime_q <= `BSR_SLAT_DEF_MS;
      steps_q <= `BSR_STEPS_DEF;
    end else begin
      if (wrCtrl && wStrb_q[0]) ctrl_q <= {wData_q[`BSR_C_BLIND], wData_q[`BSR_C_BIST]};
      if (travPass) begin
        upTime_q <= meanUp;
        dnTime_q <= meanDn;
      end else begin
        if (wrUpt) upTime_q <= (upTime_q & ~wMask[15:0]) | wMasked[15:0];
        if (wrDnt) dnTime_q <= (dnTime_q & ~wMask[15:0]) | wMasked[15:0];
      end
      if (slatPass) slatTime_q <= newSlat;
      else if (wrSlt) slatTime_q <= (slatTime_q & ~wMask[15:0]) | wMasked[15:0];
      if (wrStp && wStrb_q[0]) steps_q <= wData_q[7:0];
    end
  end

  // Read mux; status shows relays, calibration need and progress
  wire calReq = (upTime_q == 16'h0) || (dnTime_q == 16'h0);
  wire [31:0] statWord = {26'h0, fail_q, pass_q, cal_q != C_OFF, calReq, mot_q[2], mot_q[1]};
  wire rdHit = (s_axi_araddr == `BSR_A_CTRL) || (s_axi_araddr == `BSR_A_STAT)
    || (s_axi_araddr == `BSR_A_UPT) || (s_axi_araddr == `BSR_A_DNT)
    || (s_axi_araddr == `BSR_A_SLT) || (s_axi_araddr == `BSR_A_STP);
  wire [31:0] rdMux =
    (s_axi_araddr == `BSR_A_CTRL) ? {30'h0, ctrl_q.blindMode, ctrl_q.bistable} :
    (s_axi_araddr == `BSR_A_STAT) ? statWord :
    (s_axi_araddr == `BSR_A_UPT) ? {16'h0, upTime_q} :
    (s_axi_araddr == `BSR_A_DNT) ? {16'h0, dnTime_q} :
    (s_axi_araddr == `BSR_A_SLT) ? {16'h0, slatTime_q} :
    (s_axi_araddr == `BSR_A_STP) ? {24'h0, steps_q} : 32'h0;

  // AXI4-Lite write channels; address and data taken in either order
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awFull_q <= 1'b0;
      wFull_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `BSR_RESP_OK;
      awAddr_q <= '0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
    end else begin
      if (awready_q && s_axi_awvalid) begin
        awready_q <= 1'b0;
        awFull_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (!awFull_q && !bvalid_q) awready_q <= 1'b1;
      if (wready_q && s_axi_wvalid) begin
        wready_q <= 1'b0;
        wFull_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (!wFull_q && !bvalid_q) wready_q <= 1'b1;
      if (doWrite) begin
        awFull_q <= 1'b0;
        wFull_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrHit ? `BSR_RESP_OK : `BSR_RESP_DEC;
      end else if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
    end
  end

  // AXI4-Lite read channel; data one cycle after the address is taken
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `BSR_RESP_OK;
    end else begin
      if (arready_q && s_axi_arvalid) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rdMux;
        rresp_q <= rdHit ? `BSR_RESP_OK : `BSR_RESP_DEC;
      end else if (rvalid_q && s_axi_rready) rvalid_q <= 1'b0;
      else if (!rvalid_q && !arready_q) arready_q <= 1'b1;
    end
  end

  // Checks on relay behaviour and calibration outcomes
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire bistCalm = ctrl_q.bistable && !jogging && !defGo;
  a_relays_exclusive: assert property (!(upMotorRelay && downMotorRelay))
    else $error("Both relays closed");
  a_bist_up_close: assert property (bistCalm && upRise && !dnSw && motIdle && !halt_q
    |=> upMotorRelay)
    else $error("Up relay not closed by switch");
  a_bist_up_open: assert property (bistCalm && !upSw |=> !upMotorRelay)
    else $error("Up relay closed with open switch");
  a_bist_stop_change: assert property (bistCalm && !motIdle && swChange
    |=> motIdle ##1 (motIdle || !halt_q))
    else $error("Motor kept running after switch change");
  a_bist_dn_close: assert property (bistCalm && dnRise && !upSw && motIdle && !halt_q
    |=> downMotorRelay)
    else $error("Down relay not closed by switch");
  a_bist_dn_open: assert property (bistCalm && !dnSw |=> !downMotorRelay)
    else $error("Down relay closed with open switch");
  a_defaults_zero: assert property (defGo |=> upTime_q == 16'h0 && dnTime_q == 16'h0
    && slatTime_q == `BSR_SLAT_DEF_MS)
    else $error("Defaults not restored");
  a_gap_abandon: assert property ((cal_q == C_TRAV) && gapOut && !defGo
    |=> cal_q == C_OFF && fail_q)
    else $error("Travel calibration survived a long gap");
  a_trav_store: assert property (travPass && !defGo
    |=> upTime_q == $past(meanUp) && dnTime_q == $past(meanDn) ##1 upMotorRelay)
    else $error("Travel mean not stored or no jog");
  a_slat_scale: assert property (slatPass && !defGo |=> slatTime_q == $past(newSlat))
    else $error("Slat time not rescaled");
  a_slat_steps: assert property (scalGo && cal_q == C_OFF && steps_q != `BSR_STEPS_DEF
    |=> cal_q == C_OFF && fail_q)
    else $error("Slat calibration ran with wrong step count");
  a_off_delay: assert property (!jogging && startEv && startUp && limOn_d && longUp
    |=> limMs_q == $past(upFull))
    else $error("Off-delay not added to travel");
  c_trav_pass: cover property (travPass);
  c_slat_pass: cover property (slatPass);
  c_bist_stop: cover property (ctrl_q.bistable && !motIdle && swChange);
  c_short_step: cover property (!ctrl_q.bistable && startEv && limMs_d == stepMs);
endmodule : bsr_blind_ctrl
`default_nettype wire

/* dv/bsr_switch_model.sv */
// Purpose: Wall switch pair in front of the relay controller
// Assumes: Bench sets the wanted lever positions
// Notes: Changeover levers close both contacts only when allowBoth is set
`timescale 1ns/1ps
`default_nettype none
module bsr_switch_model (
  input wire logic ref_clk,
  input wire logic upCmd,
  input wire logic dnCmd,
  input wire logic allowBoth,
  output logic upSwitchInput,
  output logic downSwitchInput
);
  // Both closed only when a scenario asks for faulty wiring
  wire logic bothReq = upCmd & dnCmd & ~allowBoth;
  initial begin
    upSwitchInput = 1'b0;
    downSwitchInput = 1'b0;
  end
  // Levers move just after the edge, like any other input
  always @(posedge ref_clk) begin
    upSwitchInput <= upCmd & ~bothReq;
    downSwitchInput <= dnCmd & ~bothReq;
  end
endmodule : bsr_switch_model
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for the blind relay controller
// Assumes: MS_CYCLES is 4, so one ms is four clocks
// Notes: Timed runs carry up to 1 ms jitter, hence ranges
`timescale 1ns/1ps
`default_nettype none
`include "bsr_cfg.svh"
module tb import bsr_pkg::*;;
  localparam int MS = 4;
  logic ref_clk, reset, upCmd, dnCmd, allowBoth, upSw, dnSw, upRel, dnRel;
  logic awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, v;
  logic [1:0] bresp, rresp, resp;
  int failures, numChecks, cyc, n, u;
  bsr_switch_model i_bsr_switch_model (.ref_clk(ref_clk), .upCmd(upCmd), .dnCmd(dnCmd),
    .allowBoth(allowBoth), .upSwitchInput(upSw), .downSwitchInput(dnSw));
  bsr_blind_ctrl #(.MS_CYCLES(MS)) i_bsr_blind_ctrl (.ref_clk(ref_clk), .reset(reset),
    .upSwitchInput(upSw), .downSwitchInput(dnSw), .upMotorRelay(upRel),
    .downMotorRelay(dnRel), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp));
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (failures == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic chkr(input logic [31:0] g, input int lo, input int hi);
    numChecks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("mismatch %0t got %0d range %0d..%0d", $time, g, lo, hi);
    end
  endtask : chkr
  task automatic cw(input int ms);
    repeat (ms * MS) @(posedge ref_clk);
  endtask : cw
  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aDone, dDone;
    aDone = 1'b0;
    dDone = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(aDone && dDone)) begin
      @(posedge ref_clk);
      if (awv && awr) begin
        aDone = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wrdy) begin
        dDone = 1'b1;
        wv <= 1'b0;
      end
    end
    br <= 1'b1;
    do @(posedge ref_clk); while (bv !== 1'b1);
    br <= 1'b0;
    resp = bresp;
    @(posedge ref_clk);
  endtask : wr
  task automatic rdw(input logic [7:0] a, output logic [31:0] d);
    ara <= a;
    arv <= 1'b1;
    do @(posedge ref_clk); while (arr !== 1'b1);
    arv <= 1'b0;
    rr <= 1'b1;
    do @(posedge ref_clk); while (rv !== 1'b1);
    rr <= 1'b0;
    d = rd;
    resp = rresp;
    @(posedge ref_clk);
  endtask : rdw
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdw(a, v);
    chk(v & m, e);
  endtask : rc
  // One lever closed for ms after a short pause
  task automatic mv(input bit dn, input int ms);
    cw(10);
    if (dn) dnCmd <= 1'b1;
    else upCmd <= 1'b1;
    cw(ms);
    upCmd <= 1'b0;
    dnCmd <= 1'b0;
  endtask : mv
  task automatic meas(input bit dn, output int k);
    int t;
    k = 0;
    t = 0;
    while ((dn ? dnRel : upRel) !== 1'b1 && t < 9000) begin
      @(posedge ref_clk);
      t++;
    end
    while ((dn ? dnRel : upRel) === 1'b1) begin
      @(posedge ref_clk);
      k++;
    end
  endtask : meas
  task automatic tcal(input int a, input int b, input int c, input int d);
    wr(`BSR_A_STAT, 32'h30);
    wr(`BSR_A_CTRL, 32'h5);
    mv(0, a);
    mv(1, b);
    mv(0, c);
    mv(1, d);
  endtask : tcal
  // Short presses grouped up, down, up, down, then idle to close
  task automatic scal(input int k);
    wr(`BSR_A_STAT, 32'h30);
    wr(`BSR_A_CTRL, 32'h8);
    for (int g = 0; g < 4; g++) begin
      repeat (k) begin
        mv(g[0], 5);
        cw(102);
      end
    end
    cw(3100);
  endtask : scal
  initial begin
    {upCmd, dnCmd, allowBoth, awv, wv, br, arv, rr} = '0;
    {awa, ara, wd, failures, numChecks, cyc} = '0;
    reset = 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rc(`BSR_A_UPT, 32'hffff, 32'h0);
    rc(`BSR_A_DNT, 32'hffff, 32'h0);
    rc(`BSR_A_SLT, 32'hffff, 32'h3e8);
    rc(`BSR_A_STP, 32'hff, 32'h0a);
    chk(resp, `BSR_RESP_OK);
    rc(`BSR_A_STAT, 32'h3f, 32'h04);
    rc(8'h20, 32'hffffffff, 32'h0);
    chk(resp, `BSR_RESP_DEC);
    wr(8'h20, 32'h0);
    chk(resp, `BSR_RESP_DEC);
    wr(`BSR_A_CTRL, 32'h1);
    chk(resp, `BSR_RESP_OK);
    upCmd <= 1'b1;
    cw(5);
    chk({dnRel, upRel}, 32'h1);
    rc(`BSR_A_STAT, 32'h3, 32'h1);
    upCmd <= 1'b0;
    cw(2);
    chk(upRel, 32'h0);
    dnCmd <= 1'b1;
    cw(5);
    chk({dnRel, upRel}, 32'h2);
    dnCmd <= 1'b0;
    cw(2);
    chk(dnRel, 32'h0);
    allowBoth <= 1'b1;
    upCmd <= 1'b1;
    cw(5);
    dnCmd <= 1'b1;
    cw(2);
    chk({dnRel, upRel}, 32'h0);
    {upCmd, dnCmd, allowBoth} <= '0;
    tcal(50, 48, 55, 50);
    meas(0, n);
    chkr(n, 1196, 1204);
    meas(1, n);
    chkr(n, 1196, 1204);
    rc(`BSR_A_STAT, 32'h30, 32'h10);
    rdw(`BSR_A_UPT, v);
    chkr(v, 51, 54);
    u = v;
    rdw(`BSR_A_DNT, v);
    chkr(v, 47, 51);
    wr(`BSR_A_CTRL, 32'h0);
    fork mv(0, 400); meas(0, n); join
    chkr(n, (u + u / 20) * MS - 5, (u + u / 20) * MS + 5);
    fork mv(1, 20); meas(1, n); join
    chkr(n, 396, 404);
    tcal(70, 70, 70, 70);
    cw(20);
    rc(`BSR_A_STAT, 32'h30, 32'h20);
    rc(`BSR_A_UPT, 32'hffff, u);
    wr(`BSR_A_CTRL, 32'h11);
    rc(`BSR_A_UPT, 32'hffff, 32'h0);
    rc(`BSR_A_STAT, 32'h4, 32'h4);
    tcal(50, 50, 70, 50);
    cw(20);
    rc(`BSR_A_STAT, 32'h30, 32'h20);
    tcal(50, 50, 50, 70);
    cw(20);
    rc(`BSR_A_STAT, 32'h30, 32'h20);
    wr(`BSR_A_STAT, 32'h30);
    wr(`BSR_A_CTRL, 32'h5);
    mv(0, 50);
    cw(3100);
    rc(`BSR_A_STAT, 32'h30, 32'h20);
    wr(`BSR_A_STP, 32'h9);
    wr(`BSR_A_STAT, 32'h30);
    wr(`BSR_A_CTRL, 32'h8);
    cw(5);
    rc(`BSR_A_STAT, 32'h30, 32'h20);
    wr(`BSR_A_STP, 32'ha);
    scal(5);
    rc(`BSR_A_STAT, 32'h30, 32'h20);
    scal(12);
    rc(`BSR_A_STAT, 32'h30, 32'h10);
    rc(`BSR_A_SLT, 32'hffff, (32'h3e8 * 12) / 10);
    finish_test();
  end
endmodule : tb
`default_nettype wire
